// File: hdl/sidp_map.svh
// offsets, field positions, reset values and opcode constants of the subtract datapath
`ifndef SIDP_MAP_SVH
`define SIDP_MAP_SVH
`define SIDP_OFS_ACC            32'h0000_0000
`define SIDP_OFS_BANK           32'h0000_0004
`define SIDP_OFS_FLAGS          32'h0000_0008
`define SIDP_FLG_C              0
`define SIDP_FLG_DC             1
`define SIDP_FLG_Z              2
`define SIDP_FLG_OV             3
`define SIDP_FLG_N              4
`define SIDP_BANK_MSB           3
`define SIDP_ACC_RST            8'h00
`define SIDP_BANK_RST           4'h0
`define SIDP_FLAGS_RST          5'h00
`define SIDP_OP_ACC_MINUS_REG_B 6'h15
`define SIDP_OP_REG_MINUS_ACC   6'h17
`define SIDP_OP_LIT_MINUS_ACC   8'h08
`define SIDP_ACCESS_SPLIT       8'h80
`define SIDP_ACCESS_LOW_BANK    4'h0
`define SIDP_ACCESS_HIGH_BANK   4'hF
`endif

// File: hdl/sidp_pkg.sv
// types shared by the subtract datapath
package sidp_pkg;
   typedef enum logic [1:0] {
      PH_DECODE  = 2'b00,
      PH_READ    = 2'b01,
      PH_PROCESS = 2'b11,
      PH_WRITE   = 2'b10
   } sidp_phase_type;

   typedef enum logic [1:0] {
      OP_NONE,
      OP_ACC_MINUS_REG_BORROW,
      OP_LIT_MINUS_ACC,
      OP_REG_MINUS_ACC
   } sidp_op_type;

   typedef enum logic [1:0] {
      IDX_NONE,
      IDX_ACC,
      IDX_BANK,
      IDX_FLAGS
   } sidp_idx_type;

   typedef struct packed {
      logic n;
      logic ov;
      logic z;
      logic dc;
      logic c;
   } sidp_flags_type;

   typedef struct packed {
      sidp_op_type op;
      logic        dest_reg;
      logic        use_bank;
      logic [7:0]  field;
   } sidp_decode_type;
endpackage

// File: hdl/sidp_core.sv
// subtract instruction datapath with its ahb-lite register slave
`include "sidp_map.svh"
module sidp_core import sidp_pkg::*; (
   input  wire logic        REF_CLK,
   input  wire logic        NRST,
   input  wire logic        HSEL,
   input  wire logic [31:0] HADDR,
   input  wire logic [1:0]  HTRANS,
   input  wire logic        HWRITE,
   input  wire logic [2:0]  HSIZE,
   input  wire logic [31:0] HWDATA,
   input  wire logic        HREADY,
   output logic      [31:0] HRDATA,
   output logic             HREADYOUT,
   output logic             HRESP,
   input  wire logic [15:0] INSTR,
   input  wire logic        INSTR_VALID,
   output logic             INSTR_READY,
   output logic      [11:0] FILE_ADDR,
   input  wire logic [7:0]  FILE_RDATA,
   output logic      [7:0]  FILE_WDATA,
   output logic             FILE_WE
);
   // register offset decode, shared by the read and write paths
   function automatic sidp_idx_type bus_index(input logic [31:0] a);
      case (a)
         `SIDP_OFS_ACC:   bus_index = IDX_ACC;
         `SIDP_OFS_BANK:  bus_index = IDX_BANK;
         `SIDP_OFS_FLAGS: bus_index = IDX_FLAGS;
         default:         bus_index = IDX_NONE;
      endcase
   endfunction

   sidp_phase_type  phase_reg,     phase_next;
   sidp_decode_type dec_reg,       dec_next;
   logic [11:0]     addr_reg,      addr_next;
   logic [7:0]      operand_reg,   operand_next;
   logic [7:0]      result_reg,    result_next;
   sidp_flags_type  res_flags_reg, res_flags_next;
   logic            we_reg,        we_next;
   logic [7:0]      acc_reg,       acc_next;
   logic [3:0]      bank_reg,      bank_next;
   sidp_flags_type  flags_reg,     flags_next;
   logic            wr_pend_reg,   wr_pend_next;
   sidp_idx_type    wr_idx_reg,    wr_idx_next;
   logic [31:0]     hrdata_reg,    hrdata_next;
   logic            reg_kind;
   logic            bus_take;
   logic [7:0]      op_a;
   logic [7:0]      op_b;
   logic            op_cin;
   logic [8:0]      sum9;
   logic [4:0]      sum5;
   logic [3:0]      win_bank;

   assign reg_kind    = (dec_reg.op == OP_ACC_MINUS_REG_BORROW)
                     || (dec_reg.op == OP_REG_MINUS_ACC);
   assign bus_take    = HSEL && HTRANS[1] && HREADY;
   // no wait states and no error: every transfer completes at once
   assign HREADYOUT   = 1'b1;
   assign HRESP       = 1'b0;
   assign HRDATA      = hrdata_reg;
   assign INSTR_READY = (phase_reg == PH_DECODE);
   assign FILE_ADDR   = addr_reg;
   assign FILE_WDATA  = result_reg;
   assign FILE_WE     = we_reg;

   // operand choice for the adder: a minus b as a plus not b plus carry in
   always_comb begin
      op_a   = acc_reg;
      op_b   = operand_reg;
      op_cin = 1'b1;
      case (dec_reg.op)
         OP_ACC_MINUS_REG_BORROW: begin
            op_a   = acc_reg;
            op_b   = operand_reg;
            op_cin = flags_reg.c;                      // borrow is inverted carry
         end
         OP_LIT_MINUS_ACC: begin
            op_a = dec_reg.field;
            op_b = acc_reg;
         end
         OP_REG_MINUS_ACC: begin
            op_a = operand_reg;
            op_b = acc_reg;
         end
         default: begin
            op_a = acc_reg;
         end
      endcase
      sum9 = {1'b0, op_a} + {1'b0, ~op_b} + {8'h00, op_cin};
      sum5 = {1'b0, op_a[3:0]} + {1'b0, ~op_b[3:0]} + {4'h0, op_cin};
   end

   // window bank: low half of the field maps to the low bank, high half to the top bank
   assign win_bank = (INSTR[7:0] < `SIDP_ACCESS_SPLIT) ? `SIDP_ACCESS_LOW_BANK
                                                       : `SIDP_ACCESS_HIGH_BANK;

   // four-phase instruction pipeline
   always_comb begin
      phase_next     = phase_reg;
      dec_next       = dec_reg;
      addr_next      = addr_reg;
      operand_next   = operand_reg;
      result_next    = result_reg;
      res_flags_next = res_flags_reg;
      we_next        = 1'b0;
      case (phase_reg)
         PH_DECODE: begin
            phase_next        = PH_READ;
            dec_next.op       = OP_NONE;
            dec_next.dest_reg = INSTR[9];
            dec_next.use_bank = INSTR[8];
            dec_next.field    = INSTR[7:0];
            if (INSTR_VALID && INSTR[15:10] == `SIDP_OP_ACC_MINUS_REG_B) begin
               dec_next.op = OP_ACC_MINUS_REG_BORROW;
            end else if (INSTR_VALID && INSTR[15:10] == `SIDP_OP_REG_MINUS_ACC) begin
               dec_next.op = OP_REG_MINUS_ACC;
            end else if (INSTR_VALID && INSTR[15:8] == `SIDP_OP_LIT_MINUS_ACC) begin
               dec_next.op       = OP_LIT_MINUS_ACC;
               dec_next.dest_reg = 1'b0;
               dec_next.use_bank = 1'b0;
            end
            // bank select is sampled now, so a late bus write cannot move the operand
            addr_next = {INSTR[8] ? bank_reg : win_bank, INSTR[7:0]};
         end
         PH_READ: begin
            phase_next   = PH_PROCESS;
            operand_next = FILE_RDATA;
         end
         PH_PROCESS: begin
            phase_next        = PH_WRITE;
            result_next       = sum9[7:0];
            res_flags_next.c  = sum9[8];
            res_flags_next.dc = sum5[4];
            res_flags_next.z  = (sum9[7:0] == 8'h00);
            res_flags_next.n  = sum9[7];
            res_flags_next.ov = (op_a[7] ^ op_b[7]) & (sum9[7] ^ op_a[7]);
            we_next           = reg_kind && dec_reg.dest_reg;
         end
         PH_WRITE: begin
            phase_next = PH_DECODE;
         end
         default: begin
            phase_next = PH_DECODE;
         end
      endcase
   end

   always_ff @(posedge REF_CLK) begin
      if (!NRST) begin
         phase_reg     <= PH_DECODE;
         dec_reg       <= '0;
         addr_reg      <= 12'h000;
         operand_reg   <= 8'h00;
         result_reg    <= 8'h00;
         res_flags_reg <= '0;
         we_reg        <= 1'b0;
      end else begin
         phase_reg     <= phase_next;
         dec_reg       <= dec_next;
         addr_reg      <= addr_next;
         operand_reg   <= operand_next;
         result_reg    <= result_next;
         res_flags_reg <= res_flags_next;
         we_reg        <= we_next;
      end
   end

   // architectural state; the instruction retiring wins over a bus write in the same cycle
   always_comb begin
      acc_next   = acc_reg;
      bank_next  = bank_reg;
      flags_next = flags_reg;
      if (wr_pend_reg) begin
         case (wr_idx_reg)
            IDX_ACC:   acc_next = HWDATA[7:0];
            IDX_BANK:  bank_next = HWDATA[`SIDP_BANK_MSB:0];
            IDX_FLAGS: begin
               flags_next.c  = HWDATA[`SIDP_FLG_C];
               flags_next.dc = HWDATA[`SIDP_FLG_DC];
               flags_next.z  = HWDATA[`SIDP_FLG_Z];
               flags_next.ov = HWDATA[`SIDP_FLG_OV];
               flags_next.n  = HWDATA[`SIDP_FLG_N];
            end
            default: acc_next = acc_reg;
         endcase
      end
      if (phase_reg == PH_WRITE && dec_reg.op != OP_NONE) begin
         flags_next = res_flags_reg;
         if (!dec_reg.dest_reg) begin
            acc_next = result_reg;
         end
      end
   end

   always_ff @(posedge REF_CLK) begin
      if (!NRST) begin
         acc_reg   <= `SIDP_ACC_RST;
         bank_reg  <= `SIDP_BANK_RST;
         flags_reg <= `SIDP_FLAGS_RST;
      end else begin
         acc_reg   <= acc_next;
         bank_reg  <= bank_next;
         flags_reg <= flags_next;
      end
   end

   // bus slave; read data comes from the next values so a write just before is seen
   always_comb begin
      wr_pend_next = bus_take && HWRITE;
      wr_idx_next  = bus_take ? bus_index(HADDR) : IDX_NONE;
      hrdata_next  = hrdata_reg;
      if (bus_take && !HWRITE) begin
         hrdata_next = 32'h0000_0000;
         case (bus_index(HADDR))
            IDX_ACC:   hrdata_next[7:0] = acc_next;
            IDX_BANK:  hrdata_next[`SIDP_BANK_MSB:0] = bank_next;
            IDX_FLAGS: begin
               hrdata_next[`SIDP_FLG_C]  = flags_next.c;
               hrdata_next[`SIDP_FLG_DC] = flags_next.dc;
               hrdata_next[`SIDP_FLG_Z]  = flags_next.z;
               hrdata_next[`SIDP_FLG_OV] = flags_next.ov;
               hrdata_next[`SIDP_FLG_N]  = flags_next.n;
            end
            default:   hrdata_next = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge REF_CLK) begin
      if (!NRST) begin
         wr_pend_reg <= 1'b0;
         wr_idx_reg  <= IDX_NONE;
         hrdata_reg  <= 32'h0000_0000;
      end else begin
         wr_pend_reg <= wr_pend_next;
         wr_idx_reg  <= wr_idx_next;
         hrdata_reg  <= hrdata_next;
      end
   end

   phase_walk_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
      phase_reg == PH_DECODE |=> phase_reg == PH_READ ##1 phase_reg == PH_PROCESS
      ##1 phase_reg == PH_WRITE ##1 phase_reg == PH_DECODE)
      else $error("phase sequence broken");

   borrow_sub_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
      phase_reg == PH_WRITE && dec_reg.op == OP_ACC_MINUS_REG_BORROW |->
      result_reg == 8'($past(acc_reg) - operand_reg - {7'h00, ~$past(flags_reg.c)}))
      else $error("borrow subtract result wrong");

   flag_update_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
      phase_reg == PH_WRITE && dec_reg.op != OP_NONE |=>
      flags_reg.z == ($past(result_reg) == 8'h00) && flags_reg.n == $past(result_reg[7]))
      else $error("zero or negative flag wrong");

   lit_sub_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
      phase_reg == PH_WRITE && dec_reg.op == OP_LIT_MINUS_ACC |->
      result_reg == 8'(dec_reg.field - $past(acc_reg)) ##1 acc_reg == $past(result_reg))
      else $error("literal subtract wrong");

   reg_minus_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
      phase_reg == PH_WRITE && dec_reg.op == OP_REG_MINUS_ACC |->
      result_reg == 8'(operand_reg - $past(acc_reg)))
      else $error("register minus accumulator wrong");

   dest_file_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
      FILE_WE == (phase_reg == PH_WRITE && reg_kind && dec_reg.dest_reg))
      else $error("file write strobe wrong");

   dest_acc_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
      phase_reg == PH_WRITE && reg_kind && !dec_reg.dest_reg |=> acc_reg == $past(result_reg))
      else $error("accumulator not written");

   window_bank_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
      phase_reg == PH_READ && !dec_reg.use_bank && dec_reg.op != OP_NONE |->
      FILE_ADDR[11:8] == ((dec_reg.field < `SIDP_ACCESS_SPLIT) ? `SIDP_ACCESS_LOW_BANK
                                                                : `SIDP_ACCESS_HIGH_BANK))
      else $error("window bank address wrong");

   bank_sel_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
      phase_reg == PH_READ && dec_reg.use_bank |-> FILE_ADDR[11:8] == $past(bank_reg))
      else $error("bank select address wrong");
endmodule

// File: testbench/sidp_core_bench.sv
// self-checking bench for the subtract datapath
`include "sidp_map.svh"
module sidp_core_bench import sidp_pkg::*; ;
   timeunit 1ns;
   timeprecision 1ps;
   logic        REF_CLK, NRST, HSEL, HWRITE, HREADYOUT, HRESP;
   logic        INSTR_VALID, INSTR_READY, FILE_WE;
   logic [31:0] HADDR, HWDATA, HRDATA;
   logic [1:0]  HTRANS;
   logic [2:0]  HSIZE;
   logic [15:0] INSTR;
   logic [11:0] FILE_ADDR;
   logic [7:0]  FILE_WDATA, FILE_RDATA;
   logic [7:0]  file_mem [0:4095];
   int          miscompares, tests_run, we_count;

   initial begin
      REF_CLK = 1'h0;
      forever #5 REF_CLK = ~REF_CLK;
   end

   sidp_core u_dut (.REF_CLK(REF_CLK), .NRST(NRST), .HSEL(HSEL), .HADDR(HADDR),
      .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(HREADYOUT),
      .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP), .INSTR(INSTR),
      .INSTR_VALID(INSTR_VALID), .INSTR_READY(INSTR_READY), .FILE_ADDR(FILE_ADDR),
      .FILE_RDATA(FILE_RDATA), .FILE_WDATA(FILE_WDATA), .FILE_WE(FILE_WE));

   // file array answers in the same cycle and takes writes at the write-phase edge
   assign FILE_RDATA = file_mem[FILE_ADDR];
   always @(posedge REF_CLK) begin
      if (FILE_WE === 1'h1) begin
         file_mem[FILE_ADDR] <= FILE_WDATA;
         we_count <= we_count + 1;
      end
   end

   task automatic print_verdict;
      $display("checks %0d mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         miscompares++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic hung;
      miscompares++;
      $display("BAD handshake wait timed out");
      print_verdict();
   endtask

   // bounded wait; hready is never assumed to come at a fixed edge
   task automatic wait_ready;
      int n;
      n = 0;
      do begin
         @(posedge REF_CLK);
         n++;
         if (n > 16) hung();
      end while (HREADYOUT !== 1'h1);
   endtask

   task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd,
                      output logic [31:0] rd);
      HSEL   <= 1'h1;
      HTRANS <= 2'h2;
      HADDR  <= a;
      HWRITE <= wr;
      wait_ready();
      HSEL   <= 1'h0;
      HTRANS <= 2'h0;
      HWDATA <= wd;
      wait_ready();
      rd = HRDATA;
      // the response is taken at the same edge as the read data
      chk("hresp", {31'h0, HRESP}, 32'h0);
   endtask

   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      logic [31:0] x;
      bus(1'h1, a, d, x);
   endtask

   task automatic rd_chk(input string what, input logic [31:0] a, input logic [31:0] exp);
      logic [31:0] x;
      bus(1'h0, a, 32'h0, x);
      chk(what, x, exp);
   endtask

   // reference result {n, ov, z, dc, c, result} of a + ~b + cin
   function automatic logic [12:0] sub_ref(input logic [7:0] a, input logic [7:0] b,
                                           input logic cin);
      logic [8:0] s;
      logic [4:0] h;
      s = {1'h0, a} + {1'h0, ~b} + 9'(cin);
      h = {1'h0, a[3:0]} + {1'h0, ~b[3:0]} + 5'(cin);
      return {s[7], (a[7] != b[7]) && (s[7] != a[7]), s[7:0] == 8'h00, h[4], s[8], s[7:0]};
   endfunction

   // offers one word, then follows its read, process and write phases
   task automatic exec(input logic [15:0] w, input logic [11:0] addr, input logic we,
                       input logic rd);
      int n;
      INSTR       <= w;
      INSTR_VALID <= 1'h1;
      n = 0;
      do begin
         @(posedge REF_CLK);
         n++;
         if (n > 8) hung();
      end while (INSTR_READY !== 1'h1);
      INSTR_VALID <= 1'h0;
      for (int k = 1; k <= 3; k++) begin
         @(posedge REF_CLK);
         if (k == 1 && rd) chk("file_addr", {20'h0, FILE_ADDR}, {20'h0, addr});
         chk("file_we", {31'h0, FILE_WE}, {31'h0, k == 3 && we});
      end
   endtask

   // kind 1 acc-reg-borrow, 2 literal (f is k), 3 reg-acc
   task automatic run_op(input int kind, input logic d, input logic a, input logic [7:0] f,
      input logic [3:0] bank, input logic [7:0] regv, input logic [7:0] accv, input logic cin);
      logic [11:0] addr;
      logic [12:0] e;
      logic [15:0] w;
      logic        dfile;
      int          we0;
      addr = {a ? bank : (f < `SIDP_ACCESS_SPLIT ? `SIDP_ACCESS_LOW_BANK
                                                  : `SIDP_ACCESS_HIGH_BANK), f};
      file_mem[addr] <= regv;
      dfile = d && kind != 2;
      w = (kind == 1) ? {`SIDP_OP_ACC_MINUS_REG_B, d, a, f}
        : (kind == 3) ? {`SIDP_OP_REG_MINUS_ACC, d, a, f} : {`SIDP_OP_LIT_MINUS_ACC, f};
      e = (kind == 1) ? sub_ref(accv, regv, cin) : sub_ref(kind == 3 ? regv : f, accv, 1'h1);
      wr(`SIDP_OFS_ACC, {24'h0, accv});
      wr(`SIDP_OFS_BANK, {28'h0, bank});
      wr(`SIDP_OFS_FLAGS, {31'h0, cin});
      we0 = we_count;
      exec(w, addr, dfile, kind != 2);
      rd_chk("acc", `SIDP_OFS_ACC, {24'h0, dfile ? accv : e[7:0]});
      rd_chk("flags", `SIDP_OFS_FLAGS, {27'h0, e[12:8]});
      chk("file", {24'h0, file_mem[addr]}, {24'h0, dfile ? e[7:0] : regv});
      chk("writes", 32'(we_count - we0), {31'h0, dfile});
   endtask

   task automatic t_regs;
      rd_chk("acc_rst", `SIDP_OFS_ACC, 32'h0);
      rd_chk("flags_rst", `SIDP_OFS_FLAGS, 32'h0);
      wr(`SIDP_OFS_BANK, 32'h0000_0005);
      rd_chk("bank", `SIDP_OFS_BANK, 32'h0000_0005);
      wr(32'h0000_000C, 32'hFFFF_FFFF);
      rd_chk("unmapped", 32'h0000_000C, 32'h0);
   endtask

   task automatic t_borrow;
      run_op(1, 1'h1, 1'h0, 8'h20, 4'h3, 8'h03, 8'h02, 1'h1);
      run_op(1, 1'h0, 1'h0, 8'h20, 4'h3, 8'h02, 8'h05, 1'h1);
      run_op(1, 1'h1, 1'h0, 8'hA0, 4'h3, 8'h01, 8'h02, 1'h0);
      run_op(1, 1'h1, 1'h1, 8'hA0, 4'h5, 8'h7F, 8'h80, 1'h1);
   endtask

   task automatic t_literal;
      run_op(2, 1'h1, 1'h0, 8'h02, 4'h0, 8'h00, 8'h01, 1'h0);
      run_op(2, 1'h0, 1'h0, 8'h02, 4'h0, 8'h00, 8'h02, 1'h0);
      run_op(2, 1'h0, 1'h0, 8'h02, 4'h0, 8'h00, 8'h03, 1'h0);
      run_op(2, 1'h0, 1'h0, 8'h80, 4'h0, 8'h00, 8'h01, 1'h0);
   endtask

   task automatic t_reg_minus;
      run_op(3, 1'h1, 1'h0, 8'h10, 4'h9, 8'h03, 8'h02, 1'h0);
      run_op(3, 1'h0, 1'h0, 8'h10, 4'h9, 8'h02, 8'h02, 1'h0);
      run_op(3, 1'h1, 1'h1, 8'hF0, 4'h9, 8'h01, 8'h02, 1'h1);
   endtask

   // unknown opcode must leave the accumulator alone and strobe no file write; then two literals back to back
   task automatic t_noop_b2b;
      logic [12:0] e;
      // only the flag field of the reference goes to the flags register
      e = sub_ref(8'h05, 8'h01, 1'h1);
      wr(`SIDP_OFS_ACC, 32'h0000_0001);
      wr(`SIDP_OFS_FLAGS, 32'h0000_0000);
      exec(16'hFFFF, 12'h0, 1'h0, 1'h0);
      rd_chk("noop_acc", `SIDP_OFS_ACC, 32'h0000_0001);
      exec({`SIDP_OP_LIT_MINUS_ACC, 8'h02}, 12'h0, 1'h0, 1'h0);
      exec({`SIDP_OP_LIT_MINUS_ACC, 8'h05}, 12'h0, 1'h0, 1'h0);
      rd_chk("b2b_acc", `SIDP_OFS_ACC, 32'h0000_0004);
      rd_chk("b2b_flags", `SIDP_OFS_FLAGS, {27'h0, e[12:8]});
   endtask

   initial begin
      miscompares = 0;
      tests_run   = 0;
      we_count    = 0;
      NRST        = 1'h0;
      HSEL        = 1'h0;
      HADDR       = 32'h0;
      HTRANS      = 2'h0;
      HWRITE      = 1'h0;
      HSIZE       = 3'h2;
      HWDATA      = 32'h0;
      INSTR       = 16'h0;
      INSTR_VALID = 1'h0;
      for (int i = 0; i < 4096; i++) file_mem[i] = 8'h00;
      repeat (10) @(posedge REF_CLK);
      NRST <= 1'h1;
      t_regs();
      t_borrow();
      t_literal();
      t_reg_minus();
      t_noop_b2b();
      print_verdict();
   end
endmodule
